// *** hw/hpc_params.svh ***
// constants for the hub port configuration register group
// assumes an 8-bit register address space written by a serial slave front end
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define HPC_LINE_PIN_SWAP_ADDR 8'hfa
`define HPC_PORT_NUMBER_REMAP_ADDR 8'hfb
`define HPC_COMMAND_AND_STATE_ADDR 8'hff
`define HPC_WP_LAST_ADDR 8'hfe

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define HPC_SWAP_UP_BIT 0
`define HPC_SWAP_P1_BIT 1
`define HPC_SWAP_P2_BIT 2
`define HPC_SWAP_MASK 8'h07
`define HPC_CMD_ATTACH_BIT 0
`define HPC_CMD_SOFT_RESET_BIT 1
`define HPC_CMD_POWER_DOWN_BIT 2
`define HPC_REG_RESET 8'h00
`define HPC_NIB_DISABLED 4'h0
`define HPC_NIB_LOGICAL_1 4'h1
`define HPC_NIB_LOGICAL_2 4'h2
`define HPC_NUM_LINES 3

`endif

// *** hw/hpc_pkg.sv ***
// types for the hub port configuration register group
// assumes hpc_params.svh is compiled alongside
package hpc_pkg;

  // one register access from the serial slave front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_access_t;

  // logical number assigned to a physical downstream port
  typedef enum logic [1:0] {
    HPC_PORT_OFF = 2'h0,
    HPC_PORT_LOG1 = 2'h1,
    HPC_PORT_LOG2 = 2'h2
  } hpc_logical_t;

  // per-port line pair
  typedef struct packed {
    logic pos;
    logic neg;
  } hpc_pair_t;

endpackage : hpc_pkg

// *** hw/hpc_line_swap.sv ***
// one data line pair swap cell, registered on both directions
// assumes the transceiver core and pads share core_clk_in
module hpc_line_swap (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // control
  input wire logic swap_in,
  // core side
  input wire hpc_pkg::hpc_pair_t core_tx_in,
  input wire hpc_pkg::hpc_pair_t core_oe_in,
  output hpc_pkg::hpc_pair_t core_rx_out,
  // pin side
  input wire hpc_pkg::hpc_pair_t pin_in,
  output hpc_pkg::hpc_pair_t pin_out,
  output hpc_pkg::hpc_pair_t pin_oe_out
);

  hpc_pkg::hpc_pair_t rx_reg, rx_next;
  hpc_pkg::hpc_pair_t tx_reg, tx_next;
  hpc_pkg::hpc_pair_t oe_reg, oe_next;

  always_comb begin
    // (R1) cross pairs
    if (swap_in) begin
      tx_next = '{pos: core_tx_in.neg, neg: core_tx_in.pos};
      oe_next = '{pos: core_oe_in.neg, neg: core_oe_in.pos};
      rx_next = '{pos: pin_in.neg, neg: pin_in.pos};
    end else begin
      tx_next = core_tx_in;
      oe_next = core_oe_in;
      rx_next = pin_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_reg <= '0;
      tx_reg <= '0;
      oe_reg <= '0;
    end else begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      oe_reg <= oe_next;
    end
  end

  assign core_rx_out = rx_reg;
  assign pin_out = tx_reg;
  assign pin_oe_out = oe_reg;

endmodule : hpc_line_swap

// *** hw/hpc_port_config_regs.sv ***
// configuration register group of a two-port hub: line swap, port remap, command/state
// assumes a serial slave front end delivers one-cycle register accesses and an ack-done pulse
`include "hpc_params.svh"

// Summary of operation
// (R1) A set swap bit exchanges positive and negative line functions on that port.
// (R2) Swap bit 0 upstream, bit 1 port 1, bit 2 port 2; rest reserved.
// (R3) Upper remap nibble picks logical number of physical port 2; zero disables.
// (R4) Lower remap nibble picks logical number of physical port 1; zero disables.
// (R5) Remap nibble values 3 through 15 behave as zero, port disabled.
// (R6) Power-down bit stops serial interface after ack; write-once, pin reset clears.
// (R7) Soft reset bit resets serial interface and returns registers to defaults.
// (R8) Soft reset bit clears itself; software never clears it.
// (R9) While attach bit is zero serial config stays active, no attach signalled.
// (R10) Writing attach bit signals upstream attach; write-once, pin reset clears.
// (R11) After attach, writes to 00h-FEh are blocked except modifiable locations.
// (R12) Swap, remap and command registers reset to zero.
// (R13) Host finishes swap and remap writes before setting attach.
module hpc_port_config_regs (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // register access from serial slave
  input wire hpc_pkg::hpc_access_t access_in,
  input wire logic ack_done_in,
  output logic [7:0] rdata_out,
  output logic wr_blocked_out,
  // serial slave control
  output logic serial_link_power_down_out,
  output logic serial_link_reset_out,
  // hub status
  output logic attach_out,
  output hpc_pkg::hpc_logical_t phys1_logical_out,
  output hpc_pkg::hpc_logical_t phys2_logical_out,
  // line pairs: index 0 upstream, 1 port 1, 2 port 2
  input wire hpc_pkg::hpc_pair_t [`HPC_NUM_LINES-1:0] core_tx_in,
  input wire hpc_pkg::hpc_pair_t [`HPC_NUM_LINES-1:0] core_oe_in,
  output hpc_pkg::hpc_pair_t [`HPC_NUM_LINES-1:0] core_rx_out,
  input wire hpc_pkg::hpc_pair_t [`HPC_NUM_LINES-1:0] pin_in,
  output hpc_pkg::hpc_pair_t [`HPC_NUM_LINES-1:0] pin_out,
  output hpc_pkg::hpc_pair_t [`HPC_NUM_LINES-1:0] pin_oe_out
);

  // ----------------------------------------
  // decode helper
  // ----------------------------------------
  // (R5) reserved codes fold to off
  function automatic hpc_pkg::hpc_logical_t hpc_map_nibble(input logic [3:0] nib);
    hpc_pkg::hpc_logical_t res;
    res = hpc_pkg::HPC_PORT_OFF;
    if (nib == `HPC_NIB_LOGICAL_1) begin
      res = hpc_pkg::HPC_PORT_LOG1;
    end else if (nib == `HPC_NIB_LOGICAL_2) begin
      res = hpc_pkg::HPC_PORT_LOG2;
    end
    return res;
  endfunction : hpc_map_nibble

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] swap_reg, swap_next;
  logic [7:0] remap_reg, remap_next;
  logic attach_reg, attach_next;
  logic pd_pend_reg, pd_pend_next;
  logic pd_reg, pd_next;
  logic srst_reg, srst_next;
  logic [7:0] rdata_reg, rdata_next;
  logic blocked_reg, blocked_next;
  hpc_pkg::hpc_logical_t p1_reg, p1_next;
  hpc_pkg::hpc_logical_t p2_reg, p2_next;

  logic wr_ok;
  logic wr_prot;
  logic [7:0] cmd_view;

  always_comb begin
    // (R11) protect 00h-fe after attach; command/state stays writable
    wr_prot = attach_reg && (access_in.addr <= `HPC_WP_LAST_ADDR);
    // (R6) interface powered down ignores all traffic
    wr_ok = access_in.wr && !wr_prot && !pd_reg;
    cmd_view = {5'h00, pd_pend_reg | pd_reg, srst_reg, attach_reg};

    swap_next = swap_reg;
    remap_next = remap_reg;
    attach_next = attach_reg;
    pd_pend_next = pd_pend_reg;
    pd_next = pd_reg;
    // (R8) self clearing pulse
    srst_next = 1'b0;
    blocked_next = access_in.wr && (wr_prot || pd_reg);
    rdata_next = rdata_reg;

    if (srst_reg) begin
      // (R7) registers back to defaults; write-once bits kept for pin reset only
      swap_next = `HPC_REG_RESET;
      remap_next = `HPC_REG_RESET;
    end else if (wr_ok) begin
      unique case (access_in.addr)
        `HPC_LINE_PIN_SWAP_ADDR: begin
          // (R2) reserved swap bits hold zero
          swap_next = access_in.wdata & `HPC_SWAP_MASK;
        end
        `HPC_PORT_NUMBER_REMAP_ADDR: begin
          remap_next = access_in.wdata;
        end
        `HPC_COMMAND_AND_STATE_ADDR: begin
          // (R10) write-once attach
          if (access_in.wdata[`HPC_CMD_ATTACH_BIT]) begin
            attach_next = 1'b1;
          end
          // (R6) power down armed, acted on after ack
          if (access_in.wdata[`HPC_CMD_POWER_DOWN_BIT]) begin
            pd_pend_next = 1'b1;
          end
          // (R7) soft reset request
          if (access_in.wdata[`HPC_CMD_SOFT_RESET_BIT]) begin
            srst_next = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // (R6) take effect only once the ack has completed
    if (pd_pend_reg && ack_done_in) begin
      pd_next = 1'b1;
    end

    if (access_in.rd && !pd_reg) begin
      unique case (access_in.addr)
        `HPC_LINE_PIN_SWAP_ADDR: rdata_next = swap_reg;
        `HPC_PORT_NUMBER_REMAP_ADDR: rdata_next = remap_reg;
        `HPC_COMMAND_AND_STATE_ADDR: rdata_next = cmd_view;
        default: rdata_next = 8'h00;
      endcase
    end

    // (R3) physical port 2 from upper nibble
    p2_next = hpc_map_nibble(remap_next[7:4]);
    // (R4) physical port 1 from lower nibble
    p1_next = hpc_map_nibble(remap_next[3:0]);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // (R12) all zero after pin reset
      swap_reg <= `HPC_REG_RESET;
      remap_reg <= `HPC_REG_RESET;
      attach_reg <= 1'b0;
      pd_pend_reg <= 1'b0;
      pd_reg <= 1'b0;
      srst_reg <= 1'b0;
      rdata_reg <= 8'h00;
      blocked_reg <= 1'b0;
      p1_reg <= hpc_pkg::HPC_PORT_OFF;
      p2_reg <= hpc_pkg::HPC_PORT_OFF;
    end else begin
      swap_reg <= swap_next;
      remap_reg <= remap_next;
      attach_reg <= attach_next;
      pd_pend_reg <= pd_pend_next;
      pd_reg <= pd_next;
      srst_reg <= srst_next;
      rdata_reg <= rdata_next;
      blocked_reg <= blocked_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign wr_blocked_out = blocked_reg;
  assign serial_link_power_down_out = pd_reg;
  assign serial_link_reset_out = srst_reg;
  // (R9) no attach signalled until the bit is set
  assign attach_out = attach_reg;
  assign phys1_logical_out = p1_reg;
  assign phys2_logical_out = p2_reg;

  // ----------------------------------------
  // line swap cells
  // ----------------------------------------
  // (R2) swap bit index equals line index
  for (genvar i = 0; i < `HPC_NUM_LINES; i++) begin : g_line
    hpc_line_swap u_swap (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .swap_in(swap_reg[i]),
      .core_tx_in(core_tx_in[i]),
      .core_oe_in(core_oe_in[i]),
      .core_rx_out(core_rx_out[i]),
      .pin_in(pin_in[i]),
      .pin_out(pin_out[i]),
      .pin_oe_out(pin_oe_out[i])
    );
  end

endmodule : hpc_port_config_regs

// *** verification/hpc_host_model.sv ***
// host side model: issues byte register accesses and write acknowledges
// assumes the bench calls its tasks; it changes signals only at falling edges
module hpc_host_model (
  // clock and read data
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  // access and acknowledge
  output hpc_pkg::hpc_access_t access_out,
  output logic ack_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    access_out = '0;
    ack_done_out = 1'b0;
  end
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk_in) access_out = '{1'b1, 1'b0, addr, data};
    @(negedge core_clk_in) access_out = '0;
    @(negedge core_clk_in);
    // ack completes three edges after the write is taken
    @(negedge core_clk_in) ack_done_out = 1'b1;
    @(negedge core_clk_in) ack_done_out = 1'b0;
  endtask : write
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge core_clk_in) access_out = '{1'b0, 1'b1, addr, 8'h00};
    @(negedge core_clk_in) access_out = '0;
    data = rdata_in;
  endtask : read
endmodule : hpc_host_model

// *** verification/hpc_port_config_regs_monitor.sv ***
// checker for the register group outputs against accesses
// assumes bind to hpc_port_config_regs; single clock domain
module hpc_port_config_regs_monitor (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire hpc_pkg::hpc_access_t access_in,
  input wire logic ack_done_in,
  input wire logic wr_blocked_out,
  input wire logic serial_link_power_down_out,
  input wire logic serial_link_reset_out,
  input wire logic attach_out,
  input wire hpc_pkg::hpc_logical_t phys1_logical_out,
  input wire hpc_pkg::hpc_logical_t phys2_logical_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic ok_wr;
  assign ok_wr = access_in.wr && !serial_link_power_down_out && !serial_link_reset_out;
  a_soft_reset_pulse: assert property (
    ok_wr && access_in.addr == 8'hff && access_in.wdata[1] |=> serial_link_reset_out ##1
    !serial_link_reset_out) else $error("soft reset pulse wrong");
  a_soft_clears_map: assert property (
    serial_link_reset_out |=> phys1_logical_out == 2'h0 && phys2_logical_out == 2'h0)
    else $error("soft reset left remap");
  a_remap_port_one: assert property (
    ok_wr && !attach_out && access_in.addr == 8'hfb |=> phys1_logical_out ==
    (($past(access_in.wdata[3:0]) < 4'h3) ? $past(access_in.wdata[1:0]) : 2'h0))
    else $error("port 1 decode wrong");
  a_remap_port_two: assert property (
    ok_wr && !attach_out && access_in.addr == 8'hfb |=> phys2_logical_out ==
    (($past(access_in.wdata[7:4]) < 4'h3) ? $past(access_in.wdata[5:4]) : 2'h0))
    else $error("port 2 decode wrong");
  a_attach_set: assert property (
    ok_wr && access_in.addr == 8'hff && access_in.wdata[1:0] == 2'h1 |=> attach_out)
    else $error("attach not set");
  a_attach_sticky: assert property (
    attach_out |=> attach_out) else $error("attach dropped");
  a_protect_blocks: assert property (
    ok_wr && attach_out && access_in.addr == 8'hfb |=> $stable(phys1_logical_out) &&
    wr_blocked_out) else $error("protected write accepted");
  a_pd_after_ack: assert property (
    $rose(serial_link_power_down_out) |-> $past(ack_done_in) || $past(ack_done_in, 2))
    else $error("power down without ack");
  a_pd_refuses: assert property (
    serial_link_power_down_out && access_in.wr |=> wr_blocked_out &&
    serial_link_power_down_out) else $error("write taken while powered down");
  c_soft_reset: cover property (serial_link_reset_out);
  c_attach: cover property ($rose(attach_out));
  c_power_down: cover property ($rose(serial_link_power_down_out));
endmodule : hpc_port_config_regs_monitor

bind hpc_port_config_regs hpc_port_config_regs_monitor hpc_port_config_regs_monitor_i (
  .core_clk_in, .resetn_in, .access_in, .ack_done_in, .wr_blocked_out,
  .serial_link_power_down_out, .serial_link_reset_out, .attach_out,
  .phys1_logical_out, .phys2_logical_out);

// *** verification/hpc_port_config_regs_test.sv ***
// self-checking bench for the hub port configuration register group
// assumes the host model drives accesses; pads idle at pos high, neg low
module hpc_port_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  hpc_pkg::hpc_access_t access_in;
  logic ack_done_in, wr_blocked_out, pd_out, srst_out, attach_out;
  logic [7:0] rdata_out;
  logic [7:0] d;
  logic [7:0] regs [4] = '{8'hfa, 8'hfb, 8'hff, 8'h10};
  hpc_pkg::hpc_logical_t phys1_out, phys2_out;
  hpc_pkg::hpc_pair_t [2:0] tx_in = 6'h2a;
  hpc_pkg::hpc_pair_t [2:0] pin_in = 6'h2a;
  hpc_pkg::hpc_pair_t [2:0] rx_out, pin_out, pin_oe_out;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  hpc_port_config_regs hpc_port_config_regs_i (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .access_in(access_in), .ack_done_in(ack_done_in),
    .rdata_out(rdata_out), .wr_blocked_out(wr_blocked_out),
    .serial_link_power_down_out(pd_out), .serial_link_reset_out(srst_out),
    .attach_out(attach_out), .phys1_logical_out(phys1_out), .phys2_logical_out(phys2_out),
    .core_tx_in(tx_in), .core_oe_in(tx_in), .core_rx_out(rx_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out));
  hpc_host_model hpc_host_model_i (.core_clk_in(core_clk_in), .rdata_in(rdata_out),
    .access_out(access_in), .ack_done_out(ack_done_in));
  always #25 core_clk_in = ~core_clk_in;
  // hang guard, far above the roughly 200 cycles needed
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(negedge core_clk_in);
    resetn_in = 1'b1;
    foreach (regs[i]) begin
      hpc_host_model_i.read(regs[i], d);
      chk("reset value", 8'h00, d);
    end
    for (int v = 0; v < 8; v++) begin
      hpc_host_model_i.write(8'hfa, 8'(v) | 8'hf8);
      hpc_host_model_i.read(8'hfa, d);
      chk("swap readback", 8'(v), d);
      for (int i = 0; i < 3; i++) begin
        chk("pin drive", v[i] ? 8'h01 : 8'h02, 8'(pin_out[i]));
        chk("pin enable", v[i] ? 8'h01 : 8'h02, 8'(pin_oe_out[i]));
        chk("core receive", v[i] ? 8'h01 : 8'h02, 8'(rx_out[i]));
      end
    end
    for (int n = 0; n < 16; n++) begin
      hpc_host_model_i.write(8'hfb, {4'(15 - n), 4'(n)});
      chk("port 1 map", n < 3 ? 8'(n) : 8'h00, 8'(phys1_out));
      chk("port 2 map", n > 12 ? 8'(15 - n) : 8'h00, 8'(phys2_out));
    end
    hpc_host_model_i.write(8'hfb, 8'h21);
    hpc_host_model_i.write(8'hff, 8'h02);
    foreach (regs[i]) begin
      hpc_host_model_i.read(regs[i], d);
      chk("after soft reset", 8'h00, d);
    end
    chk("attach idle", 8'h00, 8'(attach_out));
    hpc_host_model_i.write(8'hfb, 8'h12);
    hpc_host_model_i.write(8'hff, 8'h01);
    chk("attach", 8'h01, 8'(attach_out));
    hpc_host_model_i.write(8'hfb, 8'h21);
    chk("protected map", 8'h06, {4'h0, phys2_out, phys1_out});
    hpc_host_model_i.read(8'hff, d);
    chk("attach readback", 8'h01, d);
    hpc_host_model_i.write(8'hff, 8'h05);
    @(negedge core_clk_in);
    chk("power down", 8'h01, 8'(pd_out));
    hpc_host_model_i.read(8'hfa, d);
    chk("read while down", 8'h01, d);
    hpc_host_model_i.write(8'hfa, 8'h07);
    chk("pins after refused", 8'h2a, 8'(pin_out));
    finish_test();
  end
endmodule : hpc_port_config_regs_test
